/* srr_pkg.sv */
// Purpose: Constants for the stream rate and memory self-test register bank
// Assumes: APB access, 32-bit data, one register per aligned word
// Notes:   Offsets are register indices; byte address is four times index
// Behaviour
// [R1] Thirty-two local input rate registers hold a 2-bit rate code in bits 1-0.
// [R2] Thirty-two local output rate registers hold a 2-bit rate code in bits 1-0.
// [R3] Thirty-two backplane input rate registers hold a 2-bit rate code.
// [R4] Thirty-two backplane output rate registers hold a 2-bit rate code.
// [R5] In backplane 32 Mb/s mode the backplane rate registers are overridden.
// [R6] Software starts a self-test by writing 1000h, then 1000h plus starts.
// [R7] Bit 12 of the self-test register selects self-test mode, else scan.
// [R8] A start bit launches its memory test only on a rising transition; the code also launches when bit 12 rises with a start bit already high.
// [R9] Backplane data memory uses bits 11, 10 and 9 for go, done and pass.
// [R10] Local data memory uses bits 8, 7 and 6 for go, done and pass.
// [R11] Backplane connection memory uses bits 5, 4 and 3 for go, done, pass.
// [R12] Local connection memory uses bits 2, 1 and 0 for go, done and pass.
// [R13] A memory's done flag rises once its test sequence has finished.
// [R14] After completion the pass bit shows high for pass and low for fail.
// [R15] Reserved and read-only bits read zero or status and ignore writes.
package srr_pkg;
    localparam logic [8:0]  LOC_IN_RATE_IDX   = 9'h0CD;
    localparam logic [8:0]  LOC_OUT_RATE_IDX  = 9'h0ED;
    localparam logic [8:0]  BP_IN_RATE_IDX    = 9'h10D;
    localparam logic [8:0]  BP_OUT_RATE_IDX   = 9'h12D;
    localparam logic [8:0]  SELF_TEST_IDX     = 9'h14D;
    localparam logic [8:0]  CTRL_IDX          = 9'h150;
    localparam logic [8:0]  IRQ_STAT_IDX      = 9'h151;
    localparam logic [8:0]  IRQ_MASK_IDX      = 9'h152;
    localparam int          NUM_STREAMS       = 32;
    localparam int          NUM_MEMS          = 4;
    localparam int          RATE_W            = 2;
    localparam logic [1:0]  RATE_RESET        = 2'h0;
    localparam logic [1:0]  RATE_32M          = 2'h3;
    localparam int          BP_32M_STREAMS    = 16;
    localparam int          ST_ENABLE_BIT     = 12;
    localparam logic [15:0] ST_RESET          = 16'h0000;
    localparam int          CTRL_BP32_BIT     = 0;
    localparam int          TEST_CYCLES       = 64;
    localparam logic [3:0]  MASK_RESET        = 4'h0;
    // Go, done, pass positions per memory: index 3 is backplane data
    function automatic int go_bit(input int m);
        return 3 * m + 2;
    endfunction
endpackage

/* srr_rise.sv */
// Purpose: Rising-edge detector on a same-clock level
// Assumes: Input from logic on clk
// Notes:   None
`timescale 1ns/1ps
`default_nettype none
module srr_rise (
    input  wire logic clk,
    input  wire logic sys_rst,
    input  wire logic ce,
    input  wire logic level,
    output logic      rise
);
    logic last;
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            last <= 1'b0;
        end else if (ce) begin
            last <= level;
        end
    end
    assign rise = ce & level & ~last; // [R8]
endmodule
`default_nettype wire

/* srr_mtest.sv */
// Purpose: Stand-in sequencer for one memory self-test
// Assumes: Memory under test reports a fail level while running
// Notes:   Fixed length run; real march engine lives with the memory
`timescale 1ns/1ps
`default_nettype none
module srr_mtest (
    input  wire logic clk,
    input  wire logic sys_rst,
    input  wire logic ce,
    input  wire logic start,
    input  wire logic mem_fail,
    output logic      busy,
    output logic      done,
    output logic      pass,
    output logic      finish
);
    typedef enum logic [1:0] {IDLE, RUN, FIN} srr_mt_state_t;
    srr_mt_state_t state;
    logic [6:0]    cnt;
    logic          bad;
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            state <= IDLE;
            cnt <= 7'h00;
            bad <= 1'b0;
            done <= 1'b0;
            pass <= 1'b0;
        end else if (ce) begin
            unique case (state)
                IDLE, FIN: begin
                    if (start) begin
                        state <= RUN;
                        cnt <= 7'h00;
                        bad <= 1'b0;
                        done <= 1'b0;
                        pass <= 1'b0;
                    end
                end
                RUN: begin
                    cnt <= cnt + 7'h01;
                    bad <= bad | mem_fail;
                    if (cnt == 7'(srr_pkg::TEST_CYCLES - 1)) begin
                        state <= FIN;
                        done <= 1'b1; // [R13]
                        pass <= ~(bad | mem_fail); // [R14]
                    end
                end
            endcase
        end
    end
    assign busy = (state == RUN);
    assign finish = ce & (state == RUN)
                  & (cnt == 7'(srr_pkg::TEST_CYCLES - 1));
    run_len_a: assert property (@(posedge clk) disable iff (sys_rst)
        $rose(busy) |-> ##64 done) // [R13]
        else $error("test did not finish on time");
endmodule
`default_nettype wire

/* srr_regs.sv */
// Purpose: APB register bank for stream rates and memory self-test
// Assumes: Single clock, synchronous active-high reset
// Notes:   Unmapped addresses read zero and answer pslverr
//
// Added by the designer: the APB slave port.
`timescale 1ns/1ps
`default_nettype none
module srr_regs (
    input  wire logic        clk,
    input  wire logic        sys_rst,
    input  wire logic        ce,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic [3:0]  mem_fail,
    output logic      [63:0] local_in_rate,
    output logic      [63:0] local_out_rate,
    output logic      [63:0] bp_in_rate,
    output logic      [63:0] bp_out_rate,
    output logic             bp_32m_mode,
    output logic             self_test_enable,
    output logic      [3:0]  test_busy,
    output logic             irq
);
    logic [1:0]  lin  [srr_pkg::NUM_STREAMS];
    logic [1:0]  lout [srr_pkg::NUM_STREAMS];
    logic [1:0]  bin  [srr_pkg::NUM_STREAMS];
    logic [1:0]  bout [srr_pkg::NUM_STREAMS];
    logic        bp32;
    logic        st_en;
    logic [3:0]  go;
    logic [3:0]  done;
    logic [3:0]  pass;
    logic [3:0]  rise;
    logic [3:0]  fin;
    logic [3:0]  stat;
    logic [3:0]  mask;
    logic [31:0] rd_word;
    logic [15:0] st_word;

    wire         acc     = psel & penable & ce;
    wire         wr      = acc & pwrite;
    wire [8:0]   idx     = paddr[10:2];
    wire         aligned = (paddr[1:0] == 2'h0) & ~paddr[11];
    wire [8:0]   off_li  = idx - srr_pkg::LOC_IN_RATE_IDX;
    wire [8:0]   off_lo  = idx - srr_pkg::LOC_OUT_RATE_IDX;
    wire [8:0]   off_bi  = idx - srr_pkg::BP_IN_RATE_IDX;
    wire [8:0]   off_bo  = idx - srr_pkg::BP_OUT_RATE_IDX;
    wire         hit_li  = aligned & (off_li < 9'd32);
    wire         hit_lo  = aligned & (off_lo < 9'd32);
    wire         hit_bi  = aligned & (off_bi < 9'd32);
    wire         hit_bo  = aligned & (off_bo < 9'd32);
    wire         hit_st  = aligned & (idx == srr_pkg::SELF_TEST_IDX);
    wire         hit_ct  = aligned & (idx == srr_pkg::CTRL_IDX);
    wire         hit_is  = aligned & (idx == srr_pkg::IRQ_STAT_IDX);
    wire         hit_im  = aligned & (idx == srr_pkg::IRQ_MASK_IDX);
    wire         mapped  = hit_li | hit_lo | hit_bi | hit_bo | hit_st
                         | hit_ct | hit_is | hit_im;
    wire [3:0]   go_wr   = {pwdata[11], pwdata[8], pwdata[5], pwdata[2]};

    // Zero-wait slave: every access completes in its first access cycle
    assign pready  = 1'b1;
    assign pslverr = psel & penable & ~mapped;

    // Rate registers, only bits 1-0 stored
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            for (int i = 0; i < srr_pkg::NUM_STREAMS; i++) begin
                lin[i]  <= srr_pkg::RATE_RESET;
                lout[i] <= srr_pkg::RATE_RESET;
                bin[i]  <= srr_pkg::RATE_RESET;
                bout[i] <= srr_pkg::RATE_RESET;
            end
        end else if (wr) begin
            if (hit_li) lin[off_li[4:0]]  <= pwdata[1:0]; // [R1] [R15]
            if (hit_lo) lout[off_lo[4:0]] <= pwdata[1:0]; // [R2]
            if (hit_bi) bin[off_bi[4:0]]  <= pwdata[1:0]; // [R3]
            if (hit_bo) bout[off_bo[4:0]] <= pwdata[1:0]; // [R4]
        end
    end

    // Effective rates: 32 Mb/s mode overrides backplane registers
    always_comb begin
        for (int i = 0; i < srr_pkg::NUM_STREAMS; i++) begin
            local_in_rate[2*i +: 2]  = lin[i];
            local_out_rate[2*i +: 2] = lout[i];
            if (bp32) begin
                bp_in_rate[2*i +: 2]  = (i < srr_pkg::BP_32M_STREAMS)
                                      ? srr_pkg::RATE_32M : 2'h0; // [R5]
                bp_out_rate[2*i +: 2] = (i < srr_pkg::BP_32M_STREAMS)
                                      ? srr_pkg::RATE_32M : 2'h0; // [R5]
            end else begin
                bp_in_rate[2*i +: 2]  = bin[i];
                bp_out_rate[2*i +: 2] = bout[i];
            end
        end
    end
    assign bp_32m_mode = bp32;

    // Control, self-test enable and start bits
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            bp32  <= 1'b0;
            st_en <= 1'b0;
            go    <= 4'h0;
            mask  <= srr_pkg::MASK_RESET;
        end else if (wr) begin
            if (hit_ct) bp32 <= pwdata[srr_pkg::CTRL_BP32_BIT];
            if (hit_st) st_en <= pwdata[srr_pkg::ST_ENABLE_BIT]; // [R7]
            if (hit_st) go <= go_wr; // [R9] [R10] [R11] [R12]
            if (hit_im) mask <= pwdata[3:0];
        end
    end
    assign self_test_enable = st_en; // [R7]

    // Launch needs self-test mode, so the 1000h first write arms it
    genvar m;
    generate
        for (m = 0; m < srr_pkg::NUM_MEMS; m++) begin : g_mem
            srr_rise u_rise (
                .clk     (clk),
                .sys_rst (sys_rst),
                .ce      (ce),
                .level   (go[m] & st_en),
                .rise    (rise[m])
            ); // [R6] [R8]
            srr_mtest u_test (
                .clk      (clk),
                .sys_rst  (sys_rst),
                .ce       (ce),
                .start    (rise[m]),
                .mem_fail (mem_fail[m]),
                .busy     (test_busy[m]),
                .done     (done[m]),
                .pass     (pass[m]),
                .finish   (fin[m])
            );
        end
    endgenerate

    // Done events: sticky, write one to clear, set wins
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            stat <= 4'h0;
        end else if (ce) begin
            stat <= (stat & ~((wr & hit_is) ? pwdata[3:0] : 4'h0)) | fin;
        end
    end
    assign irq = |(stat & mask);

    // Self-test word: read-only flags come from the sequencers
    assign st_word = {3'h0, st_en,
                      go[3], done[3], pass[3],
                      go[2], done[2], pass[2],
                      go[1], done[1], pass[1],
                      go[0], done[0], pass[0]}; // [R15]

    always_comb begin
        rd_word = 32'h0000_0000;
        if (hit_li) rd_word[1:0] = lin[off_li[4:0]];
        if (hit_lo) rd_word[1:0] = lout[off_lo[4:0]];
        if (hit_bi) rd_word[1:0] = bin[off_bi[4:0]];
        if (hit_bo) rd_word[1:0] = bout[off_bo[4:0]];
        if (hit_st) rd_word[15:0] = st_word;
        if (hit_ct) rd_word[0] = bp32;
        if (hit_is) rd_word[3:0] = stat;
        if (hit_im) rd_word[3:0] = mask;
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            prdata <= 32'h0000_0000;
        end else if (ce & psel & ~penable) begin
            prdata <= rd_word;
        end
    end

    // Assertions
    bp_override_a: assert property (@(posedge clk) disable iff (sys_rst)
        bp32 |-> bp_in_rate[1:0] == 2'h3 && bp_in_rate[63:62] == 2'h0) // [R5]
        else $error("backplane override wrong");
    rate_store_a: assert property (@(posedge clk) disable iff (sys_rst)
        wr && hit_li && off_li == 9'd0 |=> local_in_rate[1:0]
        == $past(pwdata[1:0])) // [R1]
        else $error("local input rate not stored");
    lout_store_a: assert property (@(posedge clk) disable iff (sys_rst)
        wr && hit_lo && off_lo == 9'd31 |=> local_out_rate[63:62]
        == $past(pwdata[1:0])) // [R2]
        else $error("local output rate not stored");
    bin_store_a: assert property (@(posedge clk) disable iff (sys_rst)
        wr && hit_bi && off_bi == 9'd0 |=> bin[0] == $past(pwdata[1:0])) // [R3]
        else $error("backplane input rate not stored");
    bout_store_a: assert property (@(posedge clk) disable iff (sys_rst)
        wr && hit_bo && off_bo == 9'd0 |=> bout[0]
        == $past(pwdata[1:0])) // [R4]
        else $error("backplane output rate not stored");
    no_scan_go_a: assert property (@(posedge clk) disable iff (sys_rst)
        !st_en |-> rise == 4'h0) // [R7]
        else $error("launch in scan mode");
    held_go_a: assert property (@(posedge clk) disable iff (sys_rst)
        rise[3] |=> !rise[3]) // [R8]
        else $error("held start relaunched");
    launch_a: assert property (@(posedge clk) disable iff (sys_rst)
        rise[0] |=> test_busy[0] && !done[0]) // [R12]
        else $error("launch did not start test");
    done_set_a: assert property (@(posedge clk) disable iff (sys_rst)
        fin[1] |=> done[1] && stat[1]) // [R13]
        else $error("completion not flagged");
    pass_rd_a: assert property (@(posedge clk) disable iff (sys_rst)
        hit_st |-> rd_word[9] == pass[3] && rd_word[15:13] == 3'h0) // [R14]
        else $error("pass bit read wrong");
endmodule
`default_nettype wire

/* tb_top.sv */
// Purpose: Self-checking bench for the stream rate and self-test registers
// Assumes: Zero-wait APB slave, byte address is four times the index
// Notes:   Drives APB inputs at the rising edge, mem_fail at a falling edge; ce held high throughout
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic        clk      = 1'b0;
    logic        sys_rst  = 1'b1;
    logic        psel     = 1'b0;
    logic        penable  = 1'b0;
    logic        pwrite   = 1'b0;
    logic [11:0] paddr    = 12'h000;
    logic [31:0] pwdata   = 32'h0000_0000;
    logic [3:0]  mem_fail = 4'h0;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic [63:0] local_in_rate;
    logic [63:0] local_out_rate;
    logic [63:0] bp_in_rate;
    logic [63:0] bp_out_rate;
    logic        bp_32m_mode;
    logic        self_test_enable;
    logic [3:0]  test_busy;
    logic        irq;
    logic [31:0] rd;
    logic        err;
    logic        irq_a;
    logic [63:0] exp_r [4];
    logic [8:0]  bases [4];
    int          failures = 0;
    int          checked  = 0;
    int          cycles   = 0;

    srr_regs DUT (
        .clk              (clk),
        .sys_rst          (sys_rst),
        .ce               (1'b1),
        .psel             (psel),
        .penable          (penable),
        .pwrite           (pwrite),
        .paddr            (paddr),
        .pwdata           (pwdata),
        .prdata           (prdata),
        .pready           (pready),
        .pslverr          (pslverr),
        .mem_fail         (mem_fail),
        .local_in_rate    (local_in_rate),
        .local_out_rate   (local_out_rate),
        .bp_in_rate       (bp_in_rate),
        .bp_out_rate      (bp_out_rate),
        .bp_32m_mode      (bp_32m_mode),
        .self_test_enable (self_test_enable),
        .test_busy        (test_busy),
        .irq              (irq)
    );

    always #5 clk = ~clk;

    task automatic tally_and_finish;
        $display("Comparisons %0d, mismatches %0d", checked, failures);
        if (failures == 0 && checked > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // Ceiling well above the thousand or so cycles the tests need
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            failures++;
            tally_and_finish;
        end
    end

    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        checked++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask

    // Request held until pready is seen high at a rising edge
    task automatic apb(input logic w, input logic [8:0] idx,
                       input logic [31:0] d);
        @(posedge clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= {1'b0, idx, 2'b00};
        pwdata  <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) @(posedge clk);
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        // Let the accepting edge settle before outputs are compared
        @(negedge clk);
    endtask

    // Polls until all four done flags are up, bounded
    task automatic wait_done;
        for (int k = 0; k < 100; k++) begin
            apb(1'b0, srr_pkg::SELF_TEST_IDX, 32'h0);
            if (rd[10] & rd[7] & rd[4] & rd[1])
                break;
        end
    endtask

    initial begin
        bases = '{srr_pkg::LOC_IN_RATE_IDX, srr_pkg::LOC_OUT_RATE_IDX,
                  srr_pkg::BP_IN_RATE_IDX, srr_pkg::BP_OUT_RATE_IDX};
        repeat (12) @(posedge clk);
        sys_rst <= 1'b0;
        for (int a = 0; a < 4; a++) begin
            apb(1'b0, bases[a] + 9'd31, 32'h0);
            chk({32'h0, rd}, 64'h0);
            // Reserved bits written high must not stick
            for (int n = 0; n < 32; n++) begin
                exp_r[a][2*n +: 2] = 2'(n + a);
                apb(1'b1, bases[a] + 9'(n), 32'hFFFF_FFFC | 32'(n + a) % 4);
            end
            for (int n = 0; n < 32; n++) begin
                apb(1'b0, bases[a] + 9'(n), 32'h0);
                chk({32'h0, rd}, {62'h0, exp_r[a][2*n +: 2]});
            end
        end
        apb(1'b0, srr_pkg::SELF_TEST_IDX, 32'h0);
        chk({32'h0, rd}, 64'h0);
        chk(local_in_rate, exp_r[0]);
        chk(local_out_rate, exp_r[1]);
        chk(bp_in_rate, exp_r[2]);
        chk(bp_out_rate, exp_r[3]);
        // Address just below the bank is unmapped: reads zero and answers pslverr
        apb(1'b0, 9'h0CC, 32'h0);
        chk({31'h0, err, rd}, {31'h1, 32'h0});
        apb(1'b1, srr_pkg::CTRL_IDX, 32'h1);
        chk({63'h0, bp_32m_mode}, 64'h1);
        chk(bp_in_rate, {32'h0, 32'hFFFF_FFFF});
        chk(bp_out_rate, {32'h0, 32'hFFFF_FFFF});
        chk(local_in_rate, exp_r[0]);
        apb(1'b1, srr_pkg::CTRL_IDX, 32'h0);
        chk(bp_in_rate, exp_r[2]);
        chk(bp_out_rate, exp_r[3]);
        // Local data memory reports an error during the first run
        mem_fail <= 4'h4;
        apb(1'b1, srr_pkg::SELF_TEST_IDX, 32'h1000);
        chk({63'h0, self_test_enable}, 64'h1);
        apb(1'b1, srr_pkg::SELF_TEST_IDX, 32'h1924);
        wait_done;
        chk({32'h0, rd}, 64'h1FBF);
        apb(1'b0, srr_pkg::IRQ_STAT_IDX, 32'h0);
        chk({32'h0, rd}, 64'hF);
        apb(1'b1, srr_pkg::IRQ_MASK_IDX, 32'h0);
        irq_a = irq;
        apb(1'b1, srr_pkg::IRQ_MASK_IDX, 32'hF);
        chk({63'h0, irq ^ irq_a}, 64'h1);
        apb(1'b1, srr_pkg::IRQ_STAT_IDX, 32'hF);
        apb(1'b0, srr_pkg::IRQ_STAT_IDX, 32'h0);
        chk({31'h0, irq, rd}, 64'h0);
        // Starts held high plus writes to status bits: no relaunch
        apb(1'b1, srr_pkg::SELF_TEST_IDX, 32'h1FFF);
        repeat (3) @(posedge clk);
        #1 chk({60'h0, test_busy}, 64'h0);
        apb(1'b0, srr_pkg::SELF_TEST_IDX, 32'h0);
        chk({32'h0, rd}, 64'h1FBF);
        mem_fail <= 4'h0;
        apb(1'b1, srr_pkg::SELF_TEST_IDX, 32'h1000);
        apb(1'b1, srr_pkg::SELF_TEST_IDX, 32'h1924);
        apb(1'b0, srr_pkg::SELF_TEST_IDX, 32'h0);
        chk({32'h0, rd}, 64'h1924);
        #1 chk({60'h0, test_busy}, 64'hF);
        wait_done;
        chk({32'h0, rd}, 64'h1FFF);
        apb(1'b1, srr_pkg::SELF_TEST_IDX, 32'h0);
        chk({63'h0, self_test_enable}, 64'h0);
        tally_and_finish;
    end
endmodule
`default_nettype wire
